// >>> pkg/dsg_pkg.sv
// deep-sleep peripheral clock gating: shared constants and types
// assumes one system clock and a plain register port with 12-bit offsets
package dsg_pkg;

	// =====================================================
	// block placement and register offsets
	localparam logic [31:0] dsg_block_base = 32'h400fe000;
	localparam int dsg_addr_width = 12;
	localparam logic [11:0] dsg_off_run_config = 12'h060;
	localparam logic [11:0] dsg_off_run_gate = 12'h100;
	localparam logic [11:0] dsg_off_sleep_gate = 12'h110;
	localparam logic [11:0] dsg_off_deep_gate = 12'h120;
	localparam logic [11:0] dsg_off_irq_status = 12'h150;
	localparam logic [11:0] dsg_off_irq_mask = 12'h154;

	// =====================================================
	// gate register fields
	localparam int dsg_bit_pwm = 20;
	localparam int dsg_bit_adc = 16;
	localparam int dsg_bit_watchdog = 3;
	localparam logic [31:0] dsg_gate_rw_mask = 32'h00110008;
	localparam logic [31:0] dsg_deep_gate_reset = 32'h00000040;
	localparam logic [31:0] dsg_run_gate_reset = 32'h00000000;
	localparam logic [31:0] dsg_sleep_gate_reset = 32'h00000000;

	// =====================================================
	// run clock configuration fields
	localparam int dsg_bit_auto_gate = 27;
	localparam logic [31:0] dsg_run_config_rw_mask = 32'h08000000;
	localparam logic [31:0] dsg_run_config_reset = 32'h00000000;

	// =====================================================
	// interrupt fields
	localparam int dsg_irq_fault = 0;
	localparam int dsg_irq_gate_change = 1;
	localparam int dsg_irq_width = 2;
	localparam logic [1:0] dsg_irq_reset = 2'h0;

	// =====================================================
	// peripheral unit selectors
	localparam logic [1:0] dsg_unit_pwm = 2'h0;
	localparam logic [1:0] dsg_unit_adc = 2'h1;
	localparam logic [1:0] dsg_unit_watchdog = 2'h2;

	typedef enum logic [1:0] {
		dsg_mode_run,
		dsg_mode_sleep,
		dsg_mode_deep
	} dsg_mode_type;

	typedef struct packed {
		logic pwm;
		logic adc;
		logic watchdog;
	} dsg_gate_type;

	typedef struct packed {
		logic valid;
		logic [1:0] unit;
	} dsg_access_type;

endpackage

// >>> src/dsg_clock_gate.sv
// deep-sleep peripheral clock gating block with run and sleep companions
// assumes synchronous inputs on clk_sys and a master that never waits
`timescale 1ns/100ps
`default_nettype none

module dsg_clock_gate (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	// register port
	input wire logic [dsg_pkg::dsg_addr_width-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// power mode requests
	input wire logic sleep_req,
	input wire logic deep_sleep_req,
	// peripheral accesses
	input wire dsg_pkg::dsg_access_type periph_access,
	output logic bus_fault,
	// unit clock enables and interrupt
	output dsg_pkg::dsg_gate_type unit_clock_enable,
	output logic irq
);
	import dsg_pkg::*;

	// =====================================================
	// state
	logic [31:0] run_gate_reg0;
	logic [31:0] sleep_gate_reg0;
	logic [31:0] deep_sleep_gate_reg0;
	logic [31:0] run_clock_config_reg;
	logic [dsg_irq_width-1:0] irq_status;
	logic [dsg_irq_width-1:0] irq_mask;
	dsg_mode_type mode;
	dsg_mode_type next_mode;
	dsg_gate_type gate;

	// =====================================================
	// decode
	wire hit_run_gate = reg_addr == dsg_off_run_gate;
	wire hit_sleep_gate = reg_addr == dsg_off_sleep_gate;
	wire hit_deep_gate = reg_addr == dsg_off_deep_gate;
	wire hit_run_config = reg_addr == dsg_off_run_config;
	wire hit_irq_status = reg_addr == dsg_off_irq_status;
	wire hit_irq_mask = reg_addr == dsg_off_irq_mask;
	wire auto_clock_gating_select = run_clock_config_reg[dsg_bit_auto_gate];
	wire [31:0] wr_gate = reg_wdata & dsg_gate_rw_mask;
	wire [31:0] deep_keep = dsg_deep_gate_reset & ~dsg_gate_rw_mask;

	// =====================================================
	// gate source selection
	wire [31:0] sel_gate_reg =
		(auto_clock_gating_select && mode == dsg_mode_deep) ? deep_sleep_gate_reg0 :
		(auto_clock_gating_select && mode == dsg_mode_sleep) ? sleep_gate_reg0 :
		run_gate_reg0;
	wire dsg_gate_type next_gate = '{
		pwm: sel_gate_reg[dsg_bit_pwm],
		adc: sel_gate_reg[dsg_bit_adc],
		watchdog: sel_gate_reg[dsg_bit_watchdog]
	};
	wire unit_off =
		(periph_access.unit == dsg_unit_pwm && !gate.pwm) ||
		(periph_access.unit == dsg_unit_adc && !gate.adc) ||
		(periph_access.unit == dsg_unit_watchdog && !gate.watchdog);
	wire fault_event = clk_en && periph_access.valid && unit_off;
	wire change_event = clk_en && (next_gate != gate);
	wire [dsg_irq_width-1:0] irq_set = {change_event, fault_event};
	wire irq_clear = clk_en && reg_read && hit_irq_status;

	wire [31:0] read_mux =
		hit_run_gate ? run_gate_reg0 :
		hit_sleep_gate ? sleep_gate_reg0 :
		hit_deep_gate ? deep_sleep_gate_reg0 :
		hit_run_config ? run_clock_config_reg :
		hit_irq_status ? {30'h0, irq_status} :
		hit_irq_mask ? {30'h0, irq_mask} :
		32'h00000000;

	// =====================================================
	// power mode tracking
	always_comb begin
		case (mode)
			dsg_mode_run: next_mode = deep_sleep_req ? dsg_mode_deep : sleep_req ? dsg_mode_sleep : dsg_mode_run;
			dsg_mode_sleep: next_mode = deep_sleep_req ? dsg_mode_deep : sleep_req ? dsg_mode_sleep : dsg_mode_run;
			dsg_mode_deep: next_mode = deep_sleep_req ? dsg_mode_deep : sleep_req ? dsg_mode_sleep : dsg_mode_run;
			default: next_mode = dsg_mode_run;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mode <= dsg_mode_run;
		end else if (clk_en) begin
			mode <= next_mode;
		end
	end

	// =====================================================
	// gate registers
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			run_gate_reg0 <= dsg_run_gate_reset;
			sleep_gate_reg0 <= dsg_sleep_gate_reset;
			deep_sleep_gate_reg0 <= dsg_deep_gate_reset;
			run_clock_config_reg <= dsg_run_config_reset;
		end else if (clk_en && reg_write) begin
			if (hit_run_gate) begin
				run_gate_reg0 <= wr_gate;
			end
			if (hit_sleep_gate) begin
				sleep_gate_reg0 <= wr_gate;
			end
			if (hit_deep_gate) begin
				deep_sleep_gate_reg0 <= wr_gate | deep_keep;
			end
			if (hit_run_config) begin
				run_clock_config_reg <= reg_wdata & dsg_run_config_rw_mask;
			end
		end
	end

	// =====================================================
	// unit enables and fault
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			gate <= '0;
			bus_fault <= 1'b0;
		end else if (clk_en) begin
			gate <= next_gate;
			bus_fault <= fault_event;
		end
	end

	assign unit_clock_enable = gate;

	// =====================================================
	// interrupt status and read data
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irq_status <= dsg_irq_reset;
			irq_mask <= dsg_irq_reset;
			reg_rdata <= 32'h00000000;
		end else if (clk_en) begin
			irq_status <= (irq_clear ? '0 : irq_status) | irq_set;
			if (reg_write && hit_irq_mask) begin
				irq_mask <= reg_wdata[dsg_irq_width-1:0];
			end
			reg_rdata <= reg_read ? read_mux : 32'h00000000;
		end
	end

	assign irq = |(irq_status & irq_mask);

endmodule // dsg_clock_gate

`default_nettype wire

// >>> bench/dsg_clock_gate_checker.sv
// port assertions for the deep-sleep clock gate
// assumes one clock domain, bound to dsg_clock_gate
`timescale 1ns/100ps
`default_nettype none
module dsg_clock_gate_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	// register port
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	// modes, accesses, outputs
	input wire logic sleep_req,
	input wire logic deep_sleep_req,
	input wire dsg_pkg::dsg_access_type periph_access,
	input wire logic bus_fault,
	input wire dsg_pkg::dsg_gate_type unit_clock_enable,
	input wire logic irq
);
	import dsg_pkg::*;
	// ====================
	// decode and properties
	wire logic [1:0] u = periph_access.unit;
	wire logic sel_on = u == 2'h0 ? unit_clock_enable.pwm : u == 2'h1 ? unit_clock_enable.adc : u == 2'h2 ?
		unit_clock_enable.watchdog : 1'b1;
	wire logic bad = clk_en && periph_access.valid && !sel_on;
	wire logic run = clk_en && !sleep_req && !deep_sleep_req;
	wire logic rd = clk_en && reg_read;
	wire logic ro = rd && (reg_addr == dsg_off_run_gate || reg_addr == dsg_off_sleep_gate);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	fault_set_a: assert property (bad |=> bus_fault) else $error("no fault");
	fault_clear_a: assert property (clk_en && !bad |=> !bus_fault) else $error("stray fault");
	read_idle_a: assert property (clk_en && !reg_read |=> reg_rdata == 32'h0) else $error("read lingers");
	deep_read_a: assert property (rd && reg_addr == dsg_off_deep_gate |=>
		reg_rdata == (reg_rdata & dsg_gate_rw_mask | 32'h40)) else $error("deep bits");
	ro_read_a: assert property (ro |=> (reg_rdata & ~dsg_gate_rw_mask) == 32'h0) else $error("ro bit");
	gate_follow_a: assert property (reg_write && reg_addr == dsg_off_run_gate && run ##1 run [*2] |=>
		unit_clock_enable == {$past(reg_wdata[20], 3), $past(reg_wdata[16], 3), $past(reg_wdata[3], 3)})
		else $error("enable wrong");
	reset_off_a: assert property ($past(sys_rst) && !sys_rst |->
		unit_clock_enable == 3'h0 && !bus_fault && !irq) else $error("not off");
	freeze_a: assert property (!clk_en |=> $stable(unit_clock_enable)) else $error("moved");
endmodule // dsg_clock_gate_checker
bind dsg_clock_gate dsg_clock_gate_checker u_chk (.clk_sys, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_write,
	.reg_read, .reg_rdata, .sleep_req, .deep_sleep_req, .periph_access, .bus_fault, .unit_clock_enable, .irq);
`default_nettype wire

// >>> bench/dsg_clock_gate_tb.sv
// self-checking bench for the deep-sleep clock gate
// assumes the checker is bound to the design
`timescale 1ns/100ps
`default_nettype none
module deep_sleep_clock_gate_reg0_tb;
	import dsg_pkg::*;
	logic clk_sys = 0, sys_rst = 1, clk_en = 1, reg_write = 0, reg_read = 0, sleep_req = 0, deep_sleep_req = 0;
	logic [11:0] reg_addr = 12'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	dsg_access_type periph_access = '0;
	dsg_gate_type unit_clock_enable;
	logic bus_fault, irq;
	int err_total = 0, samples_checked = 0, cycles = 0, i;
	logic [11:0] ra [7] = '{12'h100, 12'h110, 12'h120, 12'h120, 12'h060, 12'h154, 12'h200};
	logic [31:0] rw [7] = '{32'hffffffff, 32'hffffffff, 32'h0, 32'hffffffff, 32'hffffffff, 32'h3, 32'hffffffff};
	logic [31:0] re [7] = '{32'h110008, 32'h110008, 32'h40, 32'h110048, 32'h8000000, 32'h3, 32'h0};
	logic [5:0] mt [5] = '{6'h29, 6'h34, 6'h39, 6'h1a, 6'h22};
	dsg_clock_gate uut (.clk_sys, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.sleep_req, .deep_sleep_req, .periph_access, .bus_fault, .unit_clock_enable, .irq);
	// ====================
	// clock, tasks and sequence
	always #2 clk_sys = ~clk_sys;
	task complete_run();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			complete_run();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task acc(input logic [1:0] u, input logic e);
		@(posedge clk_sys);
		periph_access <= '{1'b1, u};
		@(posedge clk_sys);
		periph_access.valid <= 1'b0;
		#1 chk({31'h0, bus_fault}, {31'h0, e});
	endtask
	task settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(dsg_off_deep_gate, 32'h40);
		chk({29'h0, unit_clock_enable}, 32'h0);
		for (i = 0; i < 7; i++) begin
			wr(ra[i], rw[i]);
			rd(ra[i], re[i]);
		end
		wr(dsg_off_run_gate, 32'h10000);
		settle();
		chk({29'h0, unit_clock_enable}, 32'h2);
		chk({31'h0, irq}, 32'h1);
		rd(dsg_off_irq_status, 32'h2);
		chk({31'h0, irq}, 32'h0);
		for (i = 0; i < 4; i++) acc(i[1:0], i % 2 == 0);
		wr(dsg_off_irq_mask, 32'h2);
		settle();
		chk({31'h0, irq}, 32'h0);
		rd(dsg_off_irq_status, 32'h1);
		wr(dsg_off_sleep_gate, 32'h100000);
		wr(dsg_off_deep_gate, 32'h8);
		for (i = 0; i < 5; i++) begin
			wr(dsg_off_run_config, {4'h0, mt[i][5], 27'h0});
			sleep_req <= mt[i][4];
			deep_sleep_req <= mt[i][3];
			settle();
			chk({29'h0, unit_clock_enable}, {29'h0, mt[i][2:0]});
		end
		@(posedge clk_sys);
		clk_en <= 1'b0;
		wr(dsg_off_run_gate, 32'h0);
		clk_en <= 1'b1;
		rd(dsg_off_run_gate, 32'h10000);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		#1 chk({29'h0, unit_clock_enable}, 32'h0);
		rd(dsg_off_deep_gate, 32'h40);
		rd(dsg_off_run_gate, 32'h0);
		complete_run();
	end
endmodule // deep_sleep_clock_gate_reg0_tb
`default_nettype wire
